// ==== src/aar_top.sv ====
// The placing of the registers and strobed register access are this design's own decisions.
`include "aar_cfg.svh"
module aar_top
  import aar_pkg::*;
#(
  parameter int TICK_CYCLES = `AAR_CLK_HZ,
  parameter int BAUD_CYCLES = `AAR_CLK_HZ / `AAR_BAUD,
  parameter int CTL_W       = 16,
  parameter int LOG_DEPTH   = 16
) (
  input  wire logic              ref_clk,         // 50 MHz clock
  input  wire logic              srst,            // Sync reset, high
  input  wire logic [7:0]        addr,            // Register byte address
  input  wire logic [31:0]       wdata,           // Write data
  input  wire logic              wr_stb,          // Write strobe
  input  wire logic              rd_stb,          // Read strobe
  output logic      [31:0]       rdata,           // Read data, next cycle
  input  wire logic [15:0]       freq_err_ppb,    // Freq error magnitude
  input  wire logic [CTL_W-1:0]  osc_ctl,         // Oscillator control value
  input  wire logic              sat_tracked,     // At least one satellite
  input  wire logic              rcvr_link_ok,    // Receiver messages flow
  input  wire logic [2:0]        ant_fault,       // Pins: open, short, absent
  input  wire logic              nv_fail,         // Pin: NV clock failed
  input  wire logic              setup_rxd,       // Pin: setup port in
  output logic                   setup_txd,       // Setup port out
  output logic                   major_relay_drv, // High energizes relay
  output logic                   minor_relay_drv, // High energizes relay
  output logic                   irq              // Level interrupt
);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int BW = $clog2(BAUD_CYCLES);
  localparam int LW = $clog2(LOG_DEPTH);
  localparam logic [CTL_W-1:0] CTL_MAX = '1;
  localparam logic [CTL_W-1:0] CTL_LO = CTL_W'((2**CTL_W - 1) * `AAR_OSC_PCT / 100);
  localparam logic [CTL_W-1:0] CTL_HI = CTL_MAX - CTL_LO;

  // Pin synchronisers; a level counts once stages two and three agree
  logic [4:0] s1_r, s2_r, s3_r, pin_r, pin_nxt;
  always_comb begin
    pin_nxt = (s2_r == s3_r) ? s3_r : pin_r;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_r  <= 5'h01;
      s2_r  <= 5'h01;
      s3_r  <= 5'h01;
      pin_r <= 5'h01;
    end else begin
      s1_r  <= {ant_fault, nv_fail, setup_rxd};
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      pin_r <= pin_nxt;
    end
  end
  logic rxd;
  assign rxd = pin_r[0];

  // Second tick, holdover timers, alarm evaluation, registers
  logic [TW-1:0] tick_r, tick_nxt;
  logic [16:0]   hold_r, hold_nxt, sync_lim_r, sync_lim_nxt, lock_lim_r, lock_lim_nxt;
  logic [23:0]   up_r, up_nxt;
  logic [3:0]    ist_r, ist_nxt, imask_r, imask_nxt;
  logic          test_r, test_nxt, maj_r, maj_nxt, min_r, min_nxt;
  logic [LW-1:0] log_idx_r, log_idx_nxt;
  logic [31:0]   rdata_r, rdata_nxt;
  logic          sec;
  logic [16:0]   lim_w;
  logic [3:0]    ev;
  aar_cause_t    cause_r, cause_nxt;
  logic [LW-1:0] wptr_r, wptr_nxt;
  logic [LW:0]   cnt_r, cnt_nxt;
  aar_log_t      log_mem [LOG_DEPTH];

  always_comb begin
    sec      = (tick_r == TW'(TICK_CYCLES - 1));
    tick_nxt = sec ? '0 : tick_r + 1'b1;
    up_nxt   = sec ? up_r + 24'h1 : up_r;
    if (sat_tracked) begin
      hold_nxt = '0;
    end else if (sec && hold_r != '1) begin
      hold_nxt = hold_r + 17'h1;
    end else begin
      hold_nxt = hold_r;
    end
    cause_nxt.freq = freq_err_ppb > `AAR_FERR_LIM;
    cause_nxt.sync = !sat_tracked && hold_r >= sync_lim_r;
    cause_nxt.cpu  = !rcvr_link_ok;
    cause_nxt.test = test_r;
    cause_nxt.osc  = osc_ctl <= CTL_LO || osc_ctl >= CTL_HI;
    cause_nxt.lock = !sat_tracked && hold_r >= lock_lim_r;
    cause_nxt.ant  = |pin_r[4:2];
    cause_nxt.nv   = pin_r[1];
    // Live combination, so a cleared cause drops the alarm next cycle
    maj_nxt = cause_r.freq | cause_r.sync | cause_r.cpu | cause_r.test;
    min_nxt = cause_r.osc | cause_r.lock | cause_r.ant | cause_r.nv | cause_r.test;
    ev = {min_r & ~min_nxt, maj_r & ~maj_nxt, ~min_r & min_nxt, ~maj_r & maj_nxt};
    // Out-of-range limits are clamped so a timer can never sit disabled
    lim_w = (wdata[16:0] < `AAR_LIM_MIN) ? `AAR_LIM_MIN :
            (wdata[16:0] > `AAR_LIM_MAX) ? `AAR_LIM_MAX : wdata[16:0];
    sync_lim_nxt = sync_lim_r;
    lock_lim_nxt = lock_lim_r;
    imask_nxt    = imask_r;
    test_nxt     = test_r;
    log_idx_nxt  = log_idx_r;
    ist_nxt      = ist_r;
    if (wr_stb) begin
      unique case (addr)
        `AAR_REG_IRQ_STAT: ist_nxt = ist_r & ~wdata[3:0];
        `AAR_REG_IRQ_MASK: imask_nxt = wdata[3:0];
        `AAR_REG_SYNC_LIM: sync_lim_nxt = lim_w;
        `AAR_REG_LOCK_LIM: lock_lim_nxt = lim_w;
        `AAR_REG_CTRL:     test_nxt = wdata[`AAR_CTRL_TEST];
        `AAR_REG_LOG_IDX:  log_idx_nxt = wdata[LW-1:0];
        default:           ;
      endcase
    end
    ist_nxt = ist_nxt | ev; // Set wins over a same-cycle clear
    rdata_nxt = 32'h0;
    if (rd_stb) begin
      unique case (addr)
        `AAR_REG_ALARM:    rdata_nxt = {22'h0, cause_r, min_r, maj_r};
        `AAR_REG_IRQ_STAT: rdata_nxt = {28'h0, ist_r};
        `AAR_REG_IRQ_MASK: rdata_nxt = {28'h0, imask_r};
        `AAR_REG_SYNC_LIM: rdata_nxt = {15'h0, sync_lim_r};
        `AAR_REG_LOCK_LIM: rdata_nxt = {15'h0, lock_lim_r};
        `AAR_REG_CTRL:     rdata_nxt = {31'h0, test_r};
        `AAR_REG_LOG_PTR:  rdata_nxt = {16'h0, 8'(wptr_r), 8'(cnt_r)};
        `AAR_REG_LOG_IDX:  rdata_nxt = 32'(log_idx_r);
        `AAR_REG_LOG_DATA: rdata_nxt = log_mem[log_idx_r];
        `AAR_REG_HOLD_SEC: rdata_nxt = {15'h0, hold_r};
        default:           rdata_nxt = 32'h0;
      endcase
    end
    // Log every change of the cause set, oldest entry overwritten
    wptr_nxt = wptr_r;
    cnt_nxt  = cnt_r;
    if (cause_nxt != cause_r) begin
      wptr_nxt = wptr_r + 1'b1;
      cnt_nxt  = (cnt_r == (LW+1)'(LOG_DEPTH)) ? cnt_r : cnt_r + 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tick_r     <= '0;
      up_r       <= '0;
      hold_r     <= '0;
      cause_r    <= '0;
      maj_r      <= 1'b0;
      min_r      <= 1'b0;
      sync_lim_r <= `AAR_SYNC_DEF;
      lock_lim_r <= `AAR_LOCK_DEF;
      ist_r      <= '0;
      imask_r    <= '0;
      test_r     <= 1'b0;
      log_idx_r  <= '0;
      rdata_r    <= '0;
      wptr_r     <= '0;
      cnt_r      <= '0;
    end else begin
      tick_r     <= tick_nxt;
      up_r       <= up_nxt;
      hold_r     <= hold_nxt;
      cause_r    <= cause_nxt;
      maj_r      <= maj_nxt;
      min_r      <= min_nxt;
      sync_lim_r <= sync_lim_nxt;
      lock_lim_r <= lock_lim_nxt;
      ist_r      <= ist_nxt;
      imask_r    <= imask_nxt;
      test_r     <= test_nxt;
      log_idx_r  <= log_idx_nxt;
      rdata_r    <= rdata_nxt;
      wptr_r     <= wptr_nxt;
      cnt_r      <= cnt_nxt;
    end
  end
  // Log array has no reset; the entry count says what is valid
  always_ff @(posedge ref_clk) begin
    if (!srst && cause_nxt != cause_r) begin
      log_mem[wptr_r] <= '{stamp: up_r, cause: cause_nxt};
    end
  end

  // Relays: major is fail-safe, so losing drive reads as a fault
  logic maj_drv_r, min_drv_r;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      maj_drv_r <= 1'b0;
      min_drv_r <= 1'b0;
    end else begin
      maj_drv_r <= !maj_r;
      min_drv_r <= min_r;
    end
  end
  assign major_relay_drv = maj_drv_r;
  assign minor_relay_drv = min_drv_r;
  assign irq             = |(ist_r & imask_r);
  assign rdata           = rdata_r;

  // Setup port receiver, 8N1, samples mid-bit
  aar_rx_st_t rx_st_r, rx_st_nxt;
  logic [BW-1:0] rx_cnt_r, rx_cnt_nxt;
  logic [2:0]    rx_bit_r, rx_bit_nxt;
  logic [7:0]    rx_sh_r, rx_sh_nxt;
  logic          rx_vld;
  always_comb begin
    rx_st_nxt  = rx_st_r;
    rx_cnt_nxt = (rx_cnt_r != '0) ? rx_cnt_r - 1'b1 : rx_cnt_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt  = rx_sh_r;
    rx_vld     = 1'b0;
    unique case (rx_st_r)
      RX_IDLE: if (!rxd) begin
        rx_st_nxt  = RX_START;
        rx_cnt_nxt = BW'(BAUD_CYCLES / 2);
      end
      RX_START: if (rx_cnt_r == '0) begin
        rx_st_nxt  = rxd ? RX_IDLE : RX_DATA; // Glitch is not a start
        rx_cnt_nxt = BW'(BAUD_CYCLES - 1);
        rx_bit_nxt = '0;
      end
      RX_DATA: if (rx_cnt_r == '0) begin
        rx_sh_nxt  = {rxd, rx_sh_r[7:1]};
        rx_cnt_nxt = BW'(BAUD_CYCLES - 1);
        rx_bit_nxt = rx_bit_r + 1'b1;
        if (rx_bit_r == 3'h7) rx_st_nxt = RX_STOP;
      end
      RX_STOP: if (rx_cnt_r == '0) begin
        rx_vld    = rxd;
        rx_st_nxt = RX_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_st_r  <= RX_IDLE;
      rx_cnt_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r  <= '0;
    end else begin
      rx_st_r  <= rx_st_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r  <= rx_sh_nxt;
    end
  end

  // Setup port answers; commands arriving mid-answer are dropped
  aar_tx_st_t tx_st_r, tx_st_nxt;
  logic [BW-1:0] tx_cnt_r, tx_cnt_nxt;
  logic [2:0]    tx_bit_r, tx_bit_nxt;
  logic [7:0]    tx_sh_r, tx_sh_nxt;
  logic          txd_r, txd_nxt;
  logic [LW:0]   dump_rem_r, dump_rem_nxt;
  logic [LW-1:0] dump_idx_r, dump_idx_nxt;
  always_comb begin
    tx_st_nxt    = tx_st_r;
    tx_cnt_nxt   = (tx_cnt_r != '0) ? tx_cnt_r - 1'b1 : tx_cnt_r;
    tx_bit_nxt   = tx_bit_r;
    tx_sh_nxt    = tx_sh_r;
    txd_nxt      = txd_r;
    dump_rem_nxt = dump_rem_r;
    dump_idx_nxt = dump_idx_r;
    unique case (tx_st_r)
      TX_IDLE: if (rx_vld) begin
        tx_st_nxt  = TX_START;
        tx_cnt_nxt = BW'(BAUD_CYCLES - 1);
        txd_nxt    = 1'b0;
        if (rx_sh_r == `AAR_CMD_STAT) begin
          tx_sh_nxt = cause_r;
        end else if (rx_sh_r == `AAR_CMD_DUMP) begin
          tx_sh_nxt    = 8'(cnt_r);
          dump_rem_nxt = cnt_r;
          dump_idx_nxt = (cnt_r == (LW+1)'(LOG_DEPTH)) ? wptr_r : '0;
        end else begin
          tx_sh_nxt = `AAR_ANS_BAD;
        end
      end
      TX_START: if (tx_cnt_r == '0) begin
        tx_st_nxt  = TX_DATA;
        tx_cnt_nxt = BW'(BAUD_CYCLES - 1);
        tx_bit_nxt = '0;
        txd_nxt    = tx_sh_r[0];
      end
      TX_DATA: if (tx_cnt_r == '0) begin
        tx_cnt_nxt = BW'(BAUD_CYCLES - 1);
        tx_bit_nxt = tx_bit_r + 1'b1;
        tx_sh_nxt  = {1'b0, tx_sh_r[7:1]};
        txd_nxt    = (tx_bit_r == 3'h7) ? 1'b1 : tx_sh_r[1];
        if (tx_bit_r == 3'h7) tx_st_nxt = TX_STOP;
      end
      TX_STOP: if (tx_cnt_r == '0) begin
        if (dump_rem_r != '0) begin
          tx_st_nxt    = TX_START; // Next log entry, oldest first
          tx_cnt_nxt   = BW'(BAUD_CYCLES - 1);
          txd_nxt      = 1'b0;
          tx_sh_nxt    = log_mem[dump_idx_r].cause;
          dump_idx_nxt = dump_idx_r + 1'b1;
          dump_rem_nxt = dump_rem_r - 1'b1;
        end else begin
          tx_st_nxt = TX_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_st_r    <= TX_IDLE;
      tx_cnt_r   <= '0;
      tx_bit_r   <= '0;
      tx_sh_r    <= '0;
      txd_r      <= 1'b1;
      dump_rem_r <= '0;
      dump_idx_r <= '0;
    end else begin
      tx_st_r    <= tx_st_nxt;
      tx_cnt_r   <= tx_cnt_nxt;
      tx_bit_r   <= tx_bit_nxt;
      tx_sh_r    <= tx_sh_nxt;
      txd_r      <= txd_nxt;
      dump_rem_r <= dump_rem_nxt;
      dump_idx_r <= dump_idx_nxt;
    end
  end
  assign setup_txd = txd_r;
endmodule

// ==== shared/aar_cfg.svh ====
`ifndef AAR_CFG_SVH
`define AAR_CFG_SVH
// Register offsets
`define AAR_REG_ALARM    8'h00
`define AAR_REG_IRQ_STAT 8'h04
`define AAR_REG_IRQ_MASK 8'h08
`define AAR_REG_SYNC_LIM 8'h0C
`define AAR_REG_LOCK_LIM 8'h10
`define AAR_REG_CTRL     8'h14
`define AAR_REG_LOG_PTR  8'h18
`define AAR_REG_LOG_IDX  8'h1C
`define AAR_REG_LOG_DATA 8'h20
`define AAR_REG_HOLD_SEC 8'h24
// Field positions
`define AAR_CTRL_TEST    0
`define AAR_IRQ_MAJ_SET  0
`define AAR_IRQ_MIN_SET  1
`define AAR_IRQ_MAJ_CLR  2
`define AAR_IRQ_MIN_CLR  3
// Reset values and limits, in seconds
`define AAR_SYNC_DEF     17'h01C20
`define AAR_LOCK_DEF     17'h00384
`define AAR_LIM_MIN      17'h0003C
`define AAR_LIM_MAX      17'h1517F
// Frequency error limit in parts per 10^9, oscillator margin in percent
`define AAR_FERR_LIM     16'h0064
`define AAR_OSC_PCT      10
// Timing
`define AAR_CLK_HZ       50000000
`define AAR_BAUD         9600
// Setup port command bytes and the answer to an unknown command
`define AAR_CMD_STAT     8'h53
`define AAR_CMD_DUMP     8'h44
`define AAR_ANS_BAD      8'h2A
`endif

// ==== shared/aar_pkg.sv ====
package aar_pkg;
  typedef struct packed {
    logic nv;
    logic ant;
    logic lock;
    logic osc;
    logic test;
    logic cpu;
    logic sync;
    logic freq;
  } aar_cause_t;
  typedef struct packed {
    logic [23:0] stamp;
    aar_cause_t  cause;
  } aar_log_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} aar_rx_st_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} aar_tx_st_t;
endpackage

// ==== testbench/aar_console.sv ====
module aar_console #(
  parameter int BAUD_CYCLES = 16
) (
  input  wire logic ref_clk, // Bench clock
  output logic      con_txd, // Into setup input
  input  wire logic con_rxd  // From setup output
);
  timeunit 1ns;
  timeprecision 1ps;
  initial con_txd = 1'b1;
  // Send one command, then catch the answer; the answer may start inside our stop bit
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] ans, output logic ok);
    logic [8:0] frm;
    int         n;
    frm = {cmd, 1'b0};
    for (int i = 0; i < 9; i++) begin
      @(posedge ref_clk) con_txd <= frm[i];
      repeat (BAUD_CYCLES - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk) con_txd <= 1'b1;
    for (n = 0; n < 4 * BAUD_CYCLES && con_rxd !== 1'b0; n++) @(posedge ref_clk);
    ok = (con_rxd === 1'b0);
    repeat (BAUD_CYCLES / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD_CYCLES) @(posedge ref_clk);
      ans[i] = con_rxd;
    end
    repeat (BAUD_CYCLES) @(posedge ref_clk);
    ok = ok && (con_rxd === 1'b1);
  endtask
endmodule

// ==== testbench/aar_top_assertions.sv ====
`include "aar_cfg.svh"
module aar_top_assertions #(
  parameter int CTL_W = 16
) (
  input wire logic             ref_clk,         // Clock
  input wire logic             srst,            // Reset
  input wire logic [7:0]       addr,            // Address
  input wire logic [31:0]      wdata,           // Write data
  input wire logic             wr_stb,          // Write strobe
  input wire logic             rd_stb,          // Read strobe
  input wire logic [31:0]      rdata,           // Read data
  input wire logic [15:0]      freq_err_ppb,    // Freq error
  input wire logic [CTL_W-1:0] osc_ctl,         // Osc control
  input wire logic             sat_tracked,     // Satellite seen
  input wire logic             rcvr_link_ok,    // Receiver link
  input wire logic [2:0]       ant_fault,       // Antenna pins
  input wire logic             nv_fail,         // NV failure
  input wire logic             major_relay_drv, // Major relay
  input wire logic             minor_relay_drv  // Minor relay
);
  logic [2:0] age_r;
  logic [2:0] age_nxt;
  logic       test_r;
  logic       test_nxt;
  logic       calm;
  // Age since reset skips the settling window; test bit is shadowed from bus writes
  always_comb begin
    age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
    test_nxt = (wr_stb && addr == `AAR_REG_CTRL) ? wdata[`AAR_CTRL_TEST] : test_r;
  end
  always_ff @(posedge ref_clk) begin
    age_r <= srst ? 3'h0 : age_nxt;
    test_r <= srst ? 1'b0 : test_nxt;
  end
  // Every cause absent
  assign calm = freq_err_ppb <= 16'h0064 && rcvr_link_ok && sat_tracked && osc_ctl > 16'h1999
                && osc_ctl < 16'hE666 && ant_fault == 3'h0 && !nv_fail && !test_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_freq_major: assert property (freq_err_ppb > 16'h0064 |-> ##3 !major_relay_drv)
    else $error("major relay on during frequency fault");
  a_cpu_major: assert property (!rcvr_link_ok |-> ##3 !major_relay_drv)
    else $error("major relay on during receiver loss");
  a_osc_minor: assert property (age_r == 3'h7 && (osc_ctl <= 16'h1999 || osc_ctl >= 16'hE666)
    |-> ##3 minor_relay_drv) else $error("minor relay off at trim edge");
  a_ant_minor: assert property ((age_r == 3'h7 && ant_fault != 3'h0)[*8] |-> minor_relay_drv)
    else $error("minor relay off during antenna fault");
  a_nv_minor: assert property ((age_r == 3'h7 && nv_fail)[*8] |-> minor_relay_drv)
    else $error("minor relay off during memory fault");
  a_test_both: assert property (test_r[*5] |-> !major_relay_drv && minor_relay_drv)
    else $error("test mode relays wrong");
  a_calm_relays: assert property (calm[*8] |-> major_relay_drv && !minor_relay_drv)
    else $error("relays not normal while healthy");
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
  cover property (test_r[*5]);
  cover property (!rcvr_link_ok ##3 !major_relay_drv);
  cover property (calm ##1 !sat_tracked);
endmodule
bind aar_top aar_top_assertions #(.CTL_W(CTL_W)) u_aar_chk (
  .ref_clk(ref_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .freq_err_ppb(freq_err_ppb), .osc_ctl(osc_ctl), .sat_tracked(sat_tracked),
  .rcvr_link_ok(rcvr_link_ok), .ant_fault(ant_fault), .nv_fail(nv_fail),
  .major_relay_drv(major_relay_drv), .minor_relay_drv(minor_relay_drv));

// ==== testbench/tb_aar_top.sv ====
`include "aar_cfg.svh"
module tb_aar_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, srst, wr_stb, rd_stb, sat_tracked, rcvr_link_ok, nv_fail, setup_rxd;
  logic        setup_txd, major_relay_drv, minor_relay_drv, irq, maj, mnr, ok;
  logic [7:0]  addr, c, b;
  logic [31:0] wdata, rdata, v;
  logic [15:0] freq_err_ppb, osc_ctl;
  logic [2:0]  ant_fault;
  logic [7:0]  exp_c [12] = '{8'h01, 8'h00, 8'h04, 8'h10, 8'h00, 8'h10, 8'h40, 8'h40, 8'h40, 8'h80, 8'h08, 8'h84};
  int          miscompares, tests_run, cycles;
  aar_top #(.TICK_CYCLES(20), .BAUD_CYCLES(16)) uut (
    .ref_clk(ref_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .freq_err_ppb(freq_err_ppb), .osc_ctl(osc_ctl), .sat_tracked(sat_tracked),
    .rcvr_link_ok(rcvr_link_ok), .ant_fault(ant_fault), .nv_fail(nv_fail), .setup_rxd(setup_rxd),
    .setup_txd(setup_txd), .major_relay_drv(major_relay_drv), .minor_relay_drv(minor_relay_drv), .irq(irq));
  aar_console #(.BAUD_CYCLES(16)) con (.ref_clk(ref_clk), .con_txd(setup_rxd), .con_rxd(setup_txd));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard, generous against the few thousand cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      miscompares = miscompares + 1;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) {addr, wdata, wr_stb} <= {a, d, 1'b1};
    @(posedge ref_clk) wr_stb <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe, so sample it mid-cycle there
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk) {addr, rd_stb} <= {a, 1'b1};
    @(posedge ref_clk) rd_stb <= 1'b0;
    @(negedge ref_clk) d = rdata;
  endtask
  task automatic relays(input logic [1:0] e);
    chk({30'h0, major_relay_drv, minor_relay_drv}, {30'h0, e});
  endtask
  task automatic healthy();
    @(posedge ref_clk) {freq_err_ppb, osc_ctl, sat_tracked, rcvr_link_ok, ant_fault, nv_fail} <=
      {16'h0000, 16'h8000, 1'b1, 1'b1, 3'h0, 1'b0};
    wr(`AAR_REG_CTRL, 32'h0);
    cyc(12);
  endtask
  initial begin
    {srst, addr, wdata, wr_stb, rd_stb} = {1'b1, 8'h00, 32'h00000000, 2'b00};
    {miscompares, tests_run, cycles} = {32'h0, 32'h0, 32'h0};
    {freq_err_ppb, osc_ctl, sat_tracked, rcvr_link_ok, ant_fault, nv_fail} = {16'h0, 16'h8000, 6'h30};
    cyc(20);
    srst <= 1'b0;
    cyc(12);
    relays(2'b10);
    rd(`AAR_REG_SYNC_LIM, v);
    chk(v, 32'h1C20);
    rd(`AAR_REG_LOCK_LIM, v);
    chk(v, 32'h0384);
    rd(8'h30, v);
    chk(v, 32'h0);
    rd(`AAR_REG_LOG_PTR, v);
    chk(v, 32'h0);
    // Freq, receiver, trim, antenna and NV causes alone, boundaries beside, then test mode and a mixed pair
    for (int i = 0; i < 12; i++) begin
      healthy();
      relays(2'b10);
      c = exp_c[i];
      maj = |(c & 8'h0F);
      mnr = |(c & 8'hF8);
      case (i)
        0: freq_err_ppb <= 16'h0065;
        1: freq_err_ppb <= 16'h0064;
        2: rcvr_link_ok <= 1'b0;
        3: osc_ctl <= 16'h1999;
        4: osc_ctl <= 16'h199A;
        5: osc_ctl <= 16'hE666;
        6: ant_fault <= 3'h1;
        7: ant_fault <= 3'h2;
        8: ant_fault <= 3'h4;
        9: nv_fail <= 1'b1;
        10: wr(`AAR_REG_CTRL, 32'h1);
        default: {rcvr_link_ok, nv_fail} <= 2'b01;
      endcase
      cyc(12);
      rd(`AAR_REG_ALARM, v);
      chk(v, {22'h0, c, mnr, maj});
      relays({!maj, mnr});
      if (i == 0) begin
        rd(`AAR_REG_LOG_PTR, v);
        chk(v, 32'h0101);
        wr(`AAR_REG_LOG_IDX, 32'h0);
        rd(`AAR_REG_LOG_DATA, v);
        chk(v & 32'hFF, 32'h01);
      end
    end
    // Interrupt: masked rise stays quiet, unmask shows it, one-write clears it
    healthy();
    wr(`AAR_REG_IRQ_STAT, 32'hF);
    wr(`AAR_REG_IRQ_MASK, 32'h0);
    @(posedge ref_clk) rcvr_link_ok <= 1'b0;
    cyc(8);
    chk({31'h0, irq}, 32'h0);
    wr(`AAR_REG_IRQ_MASK, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(`AAR_REG_IRQ_STAT, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    // Holdover limits clamp, lock expires at 60 s before sync at 62 s
    healthy();
    wr(`AAR_REG_SYNC_LIM, 32'hA);
    rd(`AAR_REG_SYNC_LIM, v);
    chk(v, 32'h3C);
    wr(`AAR_REG_LOCK_LIM, 32'h1FFFF);
    rd(`AAR_REG_LOCK_LIM, v);
    chk(v, 32'h1517F);
    wr(`AAR_REG_LOCK_LIM, 32'h3C);
    wr(`AAR_REG_SYNC_LIM, 32'h3E);
    @(posedge ref_clk) sat_tracked <= 1'b0;
    cyc(1212);
    relays(2'b11);
    cyc(40);
    relays(2'b01);
    @(posedge ref_clk) sat_tracked <= 1'b1;
    cyc(6);
    relays(2'b10);
    rd(`AAR_REG_HOLD_SEC, v);
    chk(v, 32'h0);
    // Mid-run reset restores default limits and empties the log
    @(posedge ref_clk) srst <= 1'b1;
    cyc(20);
    srst <= 1'b0;
    cyc(12);
    relays(2'b10);
    rd(`AAR_REG_SYNC_LIM, v);
    chk(v, 32'h1C20);
    rd(`AAR_REG_LOCK_LIM, v);
    chk(v, 32'h0384);
    rd(`AAR_REG_LOG_PTR, v);
    chk(v, 32'h0);
    // Setup port status, refusal of an unknown command, then a log dump of one entry
    @(posedge ref_clk) nv_fail <= 1'b1;
    cyc(12);
    con.xfer(`AAR_CMD_STAT, b, ok);
    chk({23'h0, ok, b}, {23'h0, 1'b1, 8'h80});
    con.xfer(8'h51, b, ok);
    chk({23'h0, ok, b}, {23'h0, 1'b1, `AAR_ANS_BAD});
    con.xfer(`AAR_CMD_DUMP, b, ok);
    chk({23'h0, ok, b}, {23'h0, 1'b1, 8'h01});
    complete_run();
  end
endmodule
